// File: verilog/fes_consts.vh
// Constants for the filter engine sequencer and resampler.
`ifndef FES_CONSTS_VH
`define FES_CONSTS_VH
// Host register offsets.
`define FES_ADDR_W          9
`define FES_REG_INC_LO      9'h007
`define FES_REG_INC_HI      9'h008
`define FES_REG_UPD_STROBE  9'h009
`define FES_REG_SPACING     9'h00a
`define FES_REG_WAIT_PRE    9'h00c
`define FES_REG_STATUS      9'h00d
`define FES_REG_CONTROL     9'h00e
`define FES_IMEM_BASE       2'b01
// Reset values.
`define FES_RST_WAIT_PRE    32'h0000_0000
`define FES_RST_CONTROL     2'h0
`define FES_RST_SPACING     12'h000
`define FES_RST_INC         56'h80_0000_0000_0000
`define FES_RST_INC_LO      32'h0000_0000
`define FES_RST_INC_HI      24'h80_0000
// Control register fields.
`define FES_CTL_RUN         0
`define FES_CTL_SYNC_EN     1
// Wait preload fields.
`define FES_WP_THR_LSB      0
`define FES_WP_DEC0_LSB     10
`define FES_WP_DEC1_LSB     20
`define FES_WP_FLD_W        10
// Instruction fields.
`define FES_OP_JUMP_BIT     8
`define FES_OP_TGT_MSB      7
`define FES_OP_TGT_LSB      3
`define FES_OP_JCOND_UNC    3'b111
`define FES_OP_JCOND_CY     3'b101
`define FES_OP_JCOND_NCY    3'b100
`define FES_OP_WAIT         9'h001
`define FES_OP_NOP          9'h080
`define FES_OP_LOOP_LD      9'h084
`define FES_OP_LOOP_MSB     20
`define FES_OP_LOOP_LSB     9
`define FES_OP_FIR_MSB      7
`define FES_OP_FIR_LSB      6
`define FES_OP_FIR_CODE     2'b11
`define FES_OP_RS_STEP_BIT  3
`define FES_OP_DEC_REQ_BIT  4
`define FES_OP_DEC_SEL_BIT  5
`define FES_OP_READS_MSB    104
`define FES_OP_READS_LSB    96
// Resampler filter geometry.
`define FES_RS_PHASES       32
`define FES_RS_TAPS         8'h06
`define FES_ACC_W           56
`define FES_FIFO_DEPTH      4
`endif

// File: verilog/fes_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module fes_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  input  wire          core_clk_i,
  input  wire          sys_rst_i,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);
  reg  [W-1:0]  mem_ff [0:D-1];
  reg  [AW-1:0] wr_ptr_ff;
  reg  [AW-1:0] rd_ptr_ff;
  reg  [AW:0]   count_ff;
  wire          push;
  wire          pop;

  assign in_ready_o  = (count_ff != D[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // fes_fifo

// File: verilog/fes_sequencer.v
// Filter engine sequencer with wait counter, resampler phase accumulator and output spacer.
`timescale 1ns/1ps
`include "fes_consts.vh"

module fes_sequencer (
  input  wire                   core_clk_i,
  input  wire                   sys_rst_i,
  input  wire                   host_wr_i,
  input  wire                   host_rd_i,
  input  wire [`FES_ADDR_W-1:0] host_addr_i,
  input  wire [31:0]            host_wdata_i,
  output wire [31:0]            host_rdata_o,
  input  wire                   sample_strobe_i,
  input  wire                   sync_input_i,
  input  wire                   gain_ready_i,
  output wire                   out_valid_o,
  output wire [4:0]             out_phase_o,
  output wire [7:0]             out_coef_base_o,
  output wire                   resample_carry_out_o,
  output wire                   wait_flag_o,
  output wire [4:0]             step_o
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg  [127:0] imem [0:31];
  reg  [31:0]  rdata_ff;
  reg  [31:0]  wait_pre_ff;
  reg  [1:0]   control_ff;
  reg  [11:0]  spacing_ff;
  reg  [31:0]  inc_lo_ff;
  reg  [23:0]  inc_hi_ff;
  reg  [55:0]  inc_act_ff;
  reg  [55:0]  acc_ff;
  reg          carry_ff;
  reg  [11:0]  wait_cnt_ff;
  reg          wait_flag_ff;
  reg  [11:0]  loop_cnt_ff;
  reg  [4:0]   pc_ff;
  reg          fir_busy_ff;
  reg  [8:0]   fir_cnt_ff;
  reg          sync_s1_ff;
  reg          sync_s2_ff;
  reg          sync_s3_ff;
  reg  [11:0]  timer_ff;
  reg          out_valid_ff;
  reg  [4:0]   out_phase_ff;
  reg  [7:0]   out_coef_ff;
  reg  [4:0]   nxt_pc;
  reg          fir_done;
  wire [127:0] instr;
  wire [8:0]   op;
  wire         is_jump;
  wire         is_wait;
  wire         is_loop;
  wire         is_fir;
  wire [56:0]  acc_sum;
  wire [5:0]   phase_rnd;
  wire [4:0]   phase_pt;
  wire [15:0]  push_data;
  wire         push_valid;
  wire         push_ready;
  wire         fifo_valid;
  wire [15:0]  fifo_data;
  wire         fifo_pop;
  wire         sync_edge;
  wire [11:0]  thr;
  wire [11:0]  dec_val;
  wire [11:0]  cnt_inc;
  wire [11:0]  cnt_sub;
  wire         run;

  // ---------------------------------------------------------------
  // Host registers
  // ---------------------------------------------------------------
  assign host_rdata_o = rdata_ff;
  assign run          = control_ff[`FES_CTL_RUN];

  always @(posedge core_clk_i) begin
    if (host_wr_i && host_addr_i[8:7] == `FES_IMEM_BASE) begin
      case (host_addr_i[1:0])
        2'd0: imem[host_addr_i[6:2]][31:0]   <= host_wdata_i;
        2'd1: imem[host_addr_i[6:2]][63:32]  <= host_wdata_i;
        2'd2: imem[host_addr_i[6:2]][95:64]  <= host_wdata_i;
        default: imem[host_addr_i[6:2]][127:96] <= host_wdata_i;
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wait_pre_ff <= `FES_RST_WAIT_PRE;
      control_ff  <= `FES_RST_CONTROL;
      spacing_ff  <= `FES_RST_SPACING;
      inc_lo_ff   <= `FES_RST_INC_LO;
      inc_hi_ff   <= `FES_RST_INC_HI;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      if (host_wr_i) begin
        case (host_addr_i)
          `FES_REG_INC_LO:   inc_lo_ff   <= host_wdata_i;
          `FES_REG_INC_HI:   inc_hi_ff   <= host_wdata_i[23:0];
          `FES_REG_SPACING:  spacing_ff  <= host_wdata_i[11:0];
          `FES_REG_WAIT_PRE: wait_pre_ff <= {2'b00, host_wdata_i[29:0]};
          `FES_REG_CONTROL:  control_ff  <= host_wdata_i[1:0];
          default: ;
        endcase
      end
      if (host_rd_i) begin
        case (host_addr_i)
          `FES_REG_INC_LO:   rdata_ff <= inc_lo_ff;
          `FES_REG_INC_HI:   rdata_ff <= {8'h00, inc_hi_ff};
          `FES_REG_SPACING:  rdata_ff <= {20'h00000, spacing_ff};
          `FES_REG_WAIT_PRE: rdata_ff <= wait_pre_ff;
          `FES_REG_STATUS:   rdata_ff <= {loop_cnt_ff, wait_cnt_ff, pc_ff, carry_ff, wait_flag_ff, fir_busy_ff};
          `FES_REG_CONTROL:  rdata_ff <= {30'h0000_0000, control_ff};
          default:           rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Sync input and frequency word transfer
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      sync_s3_ff <= 1'b0;
    end else begin
      sync_s1_ff <= sync_input_i;
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end
  assign sync_edge = sync_s2_ff & ~sync_s3_ff;

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      inc_act_ff <= `FES_RST_INC;
    end else if ((host_wr_i && host_addr_i == `FES_REG_UPD_STROBE) ||
                 (sync_edge && control_ff[`FES_CTL_SYNC_EN])) begin
      inc_act_ff <= {inc_hi_ff, inc_lo_ff};
    end
  end

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  assign instr   = imem[pc_ff];
  assign op      = instr[8:0];
  assign is_jump = op[`FES_OP_JUMP_BIT];
  assign is_wait = (instr[127:9] == 119'd0) && (op == `FES_OP_WAIT);
  assign is_loop = (op == `FES_OP_LOOP_LD);
  assign is_fir  = ~is_jump && (op[`FES_OP_FIR_MSB:`FES_OP_FIR_LSB] == `FES_OP_FIR_CODE);

  always @* begin
    nxt_pc   = pc_ff;
    fir_done = 1'b0;
    if (is_jump) begin
      case (op[2:0])
        `FES_OP_JCOND_UNC: nxt_pc = op[`FES_OP_TGT_MSB:`FES_OP_TGT_LSB];
        `FES_OP_JCOND_CY:  nxt_pc = carry_ff ? op[`FES_OP_TGT_MSB:`FES_OP_TGT_LSB] : pc_ff + 5'd1;
        `FES_OP_JCOND_NCY: nxt_pc = carry_ff ? pc_ff + 5'd1 : op[`FES_OP_TGT_MSB:`FES_OP_TGT_LSB];
        default:           nxt_pc = pc_ff + 5'd1;
      endcase
    end else if (is_wait) begin
      nxt_pc = wait_flag_ff ? pc_ff + 5'd1 : pc_ff;
    end else if (is_fir) begin
      // Push back-pressure holds the filter step until the FIFO accepts.
      // A stopped engine completes nothing, so no stray accumulator step or push.
      fir_done = run && fir_busy_ff && (fir_cnt_ff == 9'd0) && push_ready;
      nxt_pc   = fir_done ? pc_ff + 5'd1 : pc_ff;
    end else begin
      nxt_pc = pc_ff + 5'd1;
    end
  end

  // ---------------------------------------------------------------
  // Program counter and loop counter
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pc_ff       <= 5'd0;
      fir_busy_ff <= 1'b0;
      fir_cnt_ff  <= 9'd0;
      loop_cnt_ff <= 12'd0;
    end else if (!run) begin
      pc_ff       <= 5'd0;
      fir_busy_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      if (is_loop) begin
        loop_cnt_ff <= instr[`FES_OP_LOOP_MSB:`FES_OP_LOOP_LSB];
      end
      if (is_fir && !fir_busy_ff) begin
        fir_busy_ff <= 1'b1;
        fir_cnt_ff  <= instr[`FES_OP_READS_MSB:`FES_OP_READS_LSB];
      end else if (fir_done) begin
        fir_busy_ff <= 1'b0;
      end else if (fir_busy_ff && fir_cnt_ff != 9'd0) begin
        fir_cnt_ff <= fir_cnt_ff - 9'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wait counter
  // ---------------------------------------------------------------
  assign thr     = {2'b00, wait_pre_ff[`FES_WP_THR_LSB +: `FES_WP_FLD_W]};
  assign dec_val = instr[`FES_OP_DEC_SEL_BIT] ? {2'b00, wait_pre_ff[`FES_WP_DEC1_LSB +: `FES_WP_FLD_W]}
                                              : {2'b00, wait_pre_ff[`FES_WP_DEC0_LSB +: `FES_WP_FLD_W]};
  // Saturate at 12'hfff rather than wrap, so an overflow never clears the count.
  assign cnt_inc = (sample_strobe_i && wait_cnt_ff != 12'hfff) ? wait_cnt_ff + 12'd1 : wait_cnt_ff;
  assign cnt_sub = (fir_done && instr[`FES_OP_DEC_REQ_BIT]) ?
                   ((cnt_inc > dec_val) ? cnt_inc - dec_val : 12'd0) : cnt_inc;

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wait_cnt_ff  <= 12'd0;
      wait_flag_ff <= 1'b0;
    end else begin
      wait_cnt_ff  <= cnt_sub;
      wait_flag_ff <= (cnt_sub >= thr);
    end
  end

  // ---------------------------------------------------------------
  // Resampler phase accumulator
  // ---------------------------------------------------------------
  // 56-bit add of active increment.
  assign acc_sum    = {1'b0, acc_ff} + {1'b0, inc_act_ff};
  // Nearest of the phase points, wrapping modulo the phase count.
  assign phase_rnd  = {1'b0, acc_sum[55:51]} + {5'd0, acc_sum[50]};
  assign phase_pt   = phase_rnd[4:0];
  assign push_data  = {3'b000, phase_pt * `FES_RS_TAPS, phase_pt};
  assign push_valid = fir_done && instr[`FES_OP_RS_STEP_BIT] && acc_sum[56];

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_ff   <= 56'd0;
      carry_ff <= 1'b0;
    // Step only on enabled filter word.
    end else if (fir_done && instr[`FES_OP_RS_STEP_BIT]) begin
      acc_ff   <= acc_sum[55:0];
      carry_ff <= acc_sum[56];
    end
  end

  // ---------------------------------------------------------------
  // Output spacing FIFO and timer
  // ---------------------------------------------------------------
  // FIFO decouples irregular outputs.
  fes_fifo #(
    .W  (16),
    .D  (`FES_FIFO_DEPTH),
    .AW (2)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  assign fifo_pop = fifo_valid && gain_ready_i && (timer_ff == 12'd0);

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      timer_ff     <= 12'd0;
      out_valid_ff <= 1'b0;
      out_phase_ff <= 5'd0;
      out_coef_ff  <= 8'd0;
    end else begin
      out_valid_ff <= fifo_pop;
      if (fifo_pop) begin
        timer_ff     <= spacing_ff;
        out_phase_ff <= fifo_data[4:0];
        out_coef_ff  <= fifo_data[12:5];
      end else if (timer_ff != 12'd0) begin
        timer_ff <= timer_ff - 12'd1;
      end
    end
  end

  assign out_valid_o          = out_valid_ff;
  assign out_phase_o          = out_phase_ff;
  assign out_coef_base_o      = out_coef_ff;
  assign resample_carry_out_o = carry_ff;
  assign wait_flag_o          = wait_flag_ff;
  assign step_o               = pc_ff;
endmodule // fes_sequencer

// File: bench/fes_seq_props.sv
// Port-level assertions for the filter engine sequencer.
`timescale 1ns/1ps
`include "fes_consts.vh"
module fes_seq_props (
  input wire                   core_clk_i,
  input wire                   sys_rst_i,
  input wire                   host_wr_i,
  input wire                   host_rd_i,
  input wire [`FES_ADDR_W-1:0] host_addr_i,
  input wire [31:0]            host_wdata_i,
  input wire [31:0]            host_rdata_o,
  input wire                   gain_ready_i,
  input wire                   out_valid_o,
  input wire [4:0]             out_phase_o,
  input wire [7:0]             out_coef_base_o,
  input wire                   resample_carry_out_o,
  input wire                   wait_flag_o,
  input wire [4:0]             step_o
);
  // Shadow of the last preload write, so the readback can be judged.
  reg [31:0] pre_ff;
  always @(posedge core_clk_i) begin
    if (sys_rst_i)
      pre_ff <= 32'h0000_0000;
    else if (host_wr_i && host_addr_i == `FES_REG_WAIT_PRE)
      pre_ff <= host_wdata_i;
  end
  // Shadow of the spacing field and the cycles since the last output.
  reg [11:0] sp_ff;
  reg [12:0] gap_ff;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sp_ff  <= 12'h000;
      gap_ff <= 13'h1fff;
    end else begin
      if (host_wr_i && host_addr_i == `FES_REG_SPACING) begin
        sp_ff <= host_wdata_i[11:0];
      end
      if (out_valid_o) begin
        gap_ff <= 13'h0001;
      end else if (gap_ff != 13'h1fff) begin
        gap_ff <= gap_ff + 13'h0001;
      end
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence pre_rd_s;
    host_rd_i && !host_wr_i && host_addr_i == `FES_REG_WAIT_PRE;
  endsequence
  sequence stat_rd_s;
    host_rd_i && host_addr_i == `FES_REG_STATUS;
  endsequence
  preload_back_a: assert property (pre_rd_s |=> host_rdata_o == {2'b00, pre_ff[29:0]})
    else $error("wait preload readback wrong");
  strobe_read_a: assert property (host_rd_i && host_addr_i == `FES_REG_UPD_STROBE |=> host_rdata_o == 32'h0)
    else $error("update strobe location not read as zero");
  status_view_a: assert property (stat_rd_s |=> host_rdata_o[7:1] ==
    {$past(step_o), $past(resample_carry_out_o), $past(wait_flag_o)}) else $error("status differs from ports");
  flag_boot_a: assert property ($fell(sys_rst_i) |=> wait_flag_o)
    else $error("wait flag low with zero threshold");
  coef_base_a: assert property (out_valid_o |-> out_coef_base_o == out_phase_o * 8'h06)
    else $error("coefficient base is not six times phase");
  pulse_one_a: assert property (out_valid_o && sp_ff != 12'h000 |=> !out_valid_o)
    else $error("output valid longer than one cycle with nonzero spacing");
  spacing_gap_a: assert property (out_valid_o |-> gap_ff > {1'b0, sp_ff})
    else $error("outputs closer than the programmed spacing");
  pop_ready_a: assert property (out_valid_o |-> $past(gain_ready_i))
    else $error("output sent without downstream ready");
  phase_hold_a: assert property (!out_valid_o |-> $stable(out_phase_o) && $stable(out_coef_base_o))
    else $error("output phase moved without valid");
endmodule // fes_seq_props

bind fes_sequencer fes_seq_props u_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
  .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
  .gain_ready_i(gain_ready_i), .out_valid_o(out_valid_o), .out_phase_o(out_phase_o),
  .out_coef_base_o(out_coef_base_o), .resample_carry_out_o(resample_carry_out_o),
  .wait_flag_o(wait_flag_o), .step_o(step_o)
);

// File: bench/fes_host_model.sv
// Host processor model that loads the program and reaches the registers.
`timescale 1ns/1ps
`include "fes_consts.vh"
module fes_host_model (
  input  wire                   core_clk_i,
  output reg                    host_wr_o,
  output reg                    host_rd_o,
  output reg  [`FES_ADDR_W-1:0] host_addr_o,
  output reg  [31:0]            host_wdata_o,
  input  wire [31:0]            host_rdata_i
);
  integer st, w;
  initial begin
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_addr_o = 9'h000;
    host_wdata_o = 32'h0;
  end
  task wr(input [8:0] a, input [31:0] dat);
    begin
      @(posedge core_clk_i);
      host_wr_o <= 1'b1;
      host_addr_o <= a;
      host_wdata_o <= dat;
      @(posedge core_clk_i);
      host_wr_o <= 1'b0;
    end
  endtask
  task rd(input [8:0] a, output [31:0] dat);
    begin
      @(posedge core_clk_i);
      host_rd_o <= 1'b1;
      host_addr_o <= a;
      @(posedge core_clk_i);
      host_rd_o <= 1'b0;
      @(posedge core_clk_i);
      dat = host_rdata_i;
    end
  endtask
  // Idle word fill.
  // Unused steps hold idle words so a stray jump cannot run stale code.
  task load(input [31:0] w0, input [31:0] w1, input [31:0] w2, input [31:0] w3, input [31:0] w4);
    reg [31:0] op;
    begin
      for (st = 0; st < 32; st = st + 1) begin
        case (st)
          0: op = w0;
          1: op = w1;
          2: op = w2;
          3: op = w3;
          4: op = w4;
          default: op = {23'h0, `FES_OP_NOP};
        endcase
        for (w = 0; w < 4; w = w + 1)
          wr({`FES_IMEM_BASE, st[4:0], w[1:0]}, (w == 0) ? op : 32'h0);
      end
    end
  endtask
endmodule // fes_host_model

// File: bench/filter_engine_sequencer_resampler_tb.sv
// Self-checking testbench for the filter engine sequencer.
`timescale 1ns/1ps
`include "fes_consts.vh"
module filter_engine_sequencer_resampler_tb;
  reg         core_clk_i, sys_rst_i, sample_strobe_i, sync_input_i, gain_ready_i;
  wire        host_wr, host_rd, out_valid_o, resample_carry_out_o, wait_flag_o;
  wire [8:0]  host_addr;
  wire [31:0] host_wdata, host_rdata;
  wire [4:0]  out_phase_o, step_o;
  wire [7:0]  out_coef_base_o;
  integer     fail_count, checked, i, k, c, cyc, last_v;
  reg [31:0]  d, r;
  reg [11:0]  lp, sp;
  reg [9:0]   thr;
  reg [63:0]  r64;
  reg [55:0]  inc, eff, acc;
  reg [56:0]  sum;
  reg [2:0]   code;
  reg [4:0]   s;
  reg [4:0]   ph;
  reg [9:0]   dc0, dc1;
  reg [4:0]   q[$];
  fes_sequencer dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .host_wr_i(host_wr), .host_rd_i(host_rd),
    .host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_rdata_o(host_rdata),
    .sample_strobe_i(sample_strobe_i), .sync_input_i(sync_input_i), .gain_ready_i(gain_ready_i),
    .out_valid_o(out_valid_o), .out_phase_o(out_phase_o), .out_coef_base_o(out_coef_base_o),
    .resample_carry_out_o(resample_carry_out_o), .wait_flag_o(wait_flag_o), .step_o(step_o));
  fes_host_model host (.core_clk_i(core_clk_i), .host_wr_o(host_wr), .host_rd_o(host_rd),
    .host_addr_o(host_addr), .host_wdata_o(host_wdata), .host_rdata_i(host_rdata));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task do_reset;
    begin
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      q.delete();
      last_v = -1000;
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin
      @(posedge core_clk_i);
      sample_strobe_i <= 1'b1;
      @(posedge core_clk_i);
      sample_strobe_i <= 1'b0;
    end
  endtask
  // Random downstream stalls exercise the buffer's back-pressure.
  always @(posedge core_clk_i) gain_ready_i <= ($urandom % 4) != 0;
  always @(posedge core_clk_i) begin
    #1;
    cyc = cyc + 1;
    if (out_valid_o === 1'b1) begin
      chk(q.size() > 0, 1);
      ph = 5'h00;
      if (q.size() > 0) ph = q.pop_front();
      chk(out_phase_o, ph);
      chk(out_coef_base_o, ph * 6);
      chk(cyc - last_v > sp, 1);
      last_v = cyc;
    end
  end
  // The whole run needs some 2000 cycles; the limit leaves wide margin.
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    {sys_rst_i, sample_strobe_i, sync_input_i} = 3'h4;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    sp = 0;
    r = $urandom(49);
    do_reset;
    thr = 2 + $urandom % 8;
    lp = $urandom;
    r = $urandom;
    host.rd(`FES_REG_UPD_STROBE, d);
    chk(d, 0);
    host.rd(9'h0ff, d);
    chk(d, 0);
    host.load(32'h1, {lp, 9'h084}, 32'h80, 32'h107, 32'h80);
    host.wr(`FES_REG_WAIT_PRE, {r[31:10], thr});
    host.rd(`FES_REG_WAIT_PRE, d);
    chk(d, {2'b00, r[29:10], thr});
    host.wr(`FES_REG_CONTROL, 32'h1);
    pulse(thr - 1);
    repeat (4) tick;
    chk(step_o, 0);
    chk(wait_flag_o, 0);
    pulse(1);
    k = 0;
    tick;
    while (step_o === 5'h00 && k < 10) begin
      tick;
      k = k + 1;
    end
    chk(k < 10, 1);
    chk(wait_flag_o, 1);
    for (i = 0; i < 8; i = i + 1) begin
      s = step_o;
      tick;
      chk(step_o, (s == 5'h03) ? 5'h00 : s + 5'h01);
    end
    pulse(3);
    host.rd(`FES_REG_STATUS, d);
    chk(d[31:20], lp);
    chk(d[19:8], thr + 3);
    $display("wait and loop test done");
    for (c = 0; c < 3; c = c + 1) begin
      do_reset;
      r64 = {$urandom, $urandom};
      inc = {1'b1, r64[54:0]};
      eff = (c == 2) ? `FES_RST_INC : inc;
      code = (c == 1) ? `FES_OP_JCOND_NCY : `FES_OP_JCOND_CY;
      sp = $urandom % 4;
      acc = 0;
      dc0 = 1 + $urandom % 3;
      dc1 = 4 + $urandom % 4;
      host.load((c == 0) ? 32'hd8 : (c == 1) ? 32'hf8 : 32'hc8, {23'h0, 1'b1, 5'h04, code}, 32'h107, 32'h80,
                32'h107);
      host.wr(`FES_REG_SPACING, sp);
      host.wr(`FES_REG_INC_LO, inc[31:0]);
      host.wr(`FES_REG_INC_HI, {8'h00, inc[55:32]});
      host.wr(`FES_REG_WAIT_PRE, {2'b00, dc1, dc0, 10'h000});
      pulse(90);
      if (c == 0) host.wr(`FES_REG_UPD_STROBE, 32'h0);
      if (c == 1) begin
        host.wr(`FES_REG_CONTROL, 32'h2);
        @(posedge core_clk_i);
        sync_input_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        sync_input_i <= 1'b0;
      end
      host.wr(`FES_REG_CONTROL, (c == 1) ? 32'h3 : 32'h1);
      for (i = 0; i < 12; i = i + 1) begin
        k = 0;
        while (step_o !== 5'h01 && k < 20) begin
          tick;
          k = k + 1;
        end
        sum = {1'b0, acc} + {1'b0, eff};
        acc = sum[55:0];
        chk(resample_carry_out_o, sum[56]);
        if (sum[56]) q.push_back(acc[55:51] + {4'h0, acc[50]});
        tick;
        chk(step_o, (sum[56] ^ (code == 3'b100)) ? 5'h04 : 5'h02);
      end
      host.wr(`FES_REG_CONTROL, 32'h0);
      repeat (40) tick;
      chk(q.size(), 0);
      host.rd(`FES_REG_STATUS, d);
      chk(d[19:8], 90 - 12 * ((c == 0) ? dc0 : (c == 1) ? dc1 : 0));
      $display("resampler case %0d done", c);
    end
    final_report;
  end
endmodule // filter_engine_sequencer_resampler_tb
